// file: pkg/pio_consts.vh
// constants and register map of the pattern I/O front end
//
// What this block does
// - software sets line direction per 16-line half, never per single line
// - three direction settings: all inputs, A/B in with C/D out, all outputs
// - same direction and I/O behaviour for general I/O and pattern transfer
// - lowest four group-A lines raise rising-edge interrupts in general I/O mode while group A is input
// - pattern input and pattern output each have their own five control lines
// - input side: ack is the only output; output side: request is the only output
// - with external clock selected, sample or advance on its falling edge
// - external start edge begins transfer; software picks rising or falling
// - external stop edge ends transfer; software picks rising or falling
// - all four request and acknowledge lines are active low
// - input accepts after request low over 50 ns, acks low after memory write
// - output drives request low, completes on ack low over 100 ns, then advances
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// ==========================================================
// register offsets (byte addresses)
`define PIO_REG_CTRL    8'h00
`define PIO_REG_DOUT    8'h04
`define PIO_REG_DIN     8'h08
`define PIO_REG_STATUS  8'h0C
`define PIO_REG_MASK    8'h10
`define PIO_REG_XFER    8'h14
`define PIO_REG_CMD     8'h18
`define PIO_REG_PATIN   8'h1C

// ==========================================================
// control register fields
`define PIO_CTRL_SET_LO   0
`define PIO_CTRL_SET_HI   1
`define PIO_CTRL_GPIO     2
`define PIO_CTRL_INEXT    3
`define PIO_CTRL_OUTEXT   4
`define PIO_CTRL_INSTR    5
`define PIO_CTRL_INSTPR   6
`define PIO_CTRL_OUTSTR   7
`define PIO_CTRL_OUTSTPR  8
`define PIO_CTRL_INHS     9
`define PIO_CTRL_OUTHS    10
`define PIO_CTRL_W        11
`define PIO_CTRL_RESET    11'h004

// direction settings
`define PIO_SET_ALL_IN    2'h0
`define PIO_SET_SPLIT     2'h1
`define PIO_SET_ALL_OUT   2'h2

// status bits: 3..0 line interrupts, then trigger events
`define PIO_ST_INSTART    4
`define PIO_ST_INSTOP     5
`define PIO_ST_OUTSTART   6
`define PIO_ST_OUTSTOP    7
`define PIO_ST_W          8

// ==========================================================
// timing
`define PIO_CLK_NS        10
`define PIO_REQ_MIN_NS    50
`define PIO_ACK_MIN_NS    100
`define PIO_ACK_OUT_NS    100
// "more than" a width: one cycle beyond the figure
`define PIO_REQ_CYC       ((`PIO_REQ_MIN_NS / `PIO_CLK_NS) + 1)
`define PIO_ACKQ_CYC      ((`PIO_ACK_MIN_NS / `PIO_CLK_NS) + 1)
`define PIO_ACKO_CYC      ((`PIO_ACK_OUT_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS)

`endif

// file: logic/pio_sync_edge.v
// two-stage synchroniser with edge detection behind it
`timescale 1ns/1ps
module pio_sync_edge #(
   parameter W = 1
) (
   input  wire         clock,
   input  wire         rst,
   input  wire [W-1:0] asyncIn,
   output wire [W-1:0] level,
   output wire [W-1:0] rise,
   output wire [W-1:0] fall
);
   reg [W-1:0] meta_ff;
   reg [W-1:0] sync_ff;
   reg [W-1:0] prev_ff;
   reg [2:0]   fill_ff;

   // ==========================================================
   // first stage feeds only the second; edges use stages two and three
   always @(posedge clock) begin
      if (rst) begin
         meta_ff <= {W{1'b0}};
         sync_ff <= {W{1'b0}};
         prev_ff <= {W{1'b0}};
         fill_ff <= 3'h0;
      end else begin
         meta_ff <= asyncIn;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         fill_ff <= {fill_ff[1:0], 1'b1};
      end
   end

   // edges stay quiet until stage three holds pin data: a pin idling high gives no edge after reset
   assign level = sync_ff;
   assign rise  = sync_ff & ~prev_ff & {W{fill_ff[2]}};
   assign fall  = ~sync_ff & prev_ff & {W{fill_ff[2]}};
endmodule // pio_sync_edge

// file: logic/pio_low_qual.v
// low-width qualifier: one pulse once a synced level has stayed low long enough
`timescale 1ns/1ps
module pio_low_qual #(
   parameter CW    = 5,
   parameter LIMIT = 6
) (
   input  wire clock,
   input  wire rst,
   input  wire lowLevel,
   output reg  qualified
);
   reg [CW-1:0] cnt_ff;
   wire         hit = (cnt_ff == LIMIT[CW-1:0] - 1'b1);

   // ==========================================================
   // count saturates at the limit so one low run gives one pulse
   always @(posedge clock) begin
      if (rst) begin
         cnt_ff    <= {CW{1'b0}};
         qualified <= 1'b0;
      end else begin
         qualified <= lowLevel & hit;
         if (!lowLevel)
            cnt_ff <= {CW{1'b0}};
         else if (cnt_ff != LIMIT[CW-1:0])
            cnt_ff <= cnt_ff + 1'b1;
      end
   end
endmodule // pio_low_qual

// file: logic/pio_front_end.v
// pattern I/O front end: direction, line interrupts, pacing and handshakes
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_front_end (
   input  wire        clock,
   input  wire        rst,
   // register port
   input  wire [7:0]  regAddr,
   input  wire [31:0] regWrData,
   input  wire        regWr,
   input  wire        regRd,
   output reg  [31:0] regRdData_ff,
   output reg         irq_ff,
   // data lines, groups a..d in bytes 0..3
   input  wire [31:0] dataIn,
   output reg  [31:0] dataOut_ff,
   output reg  [31:0] dataOe_ff,
   // pattern input control lines
   input  wire        in_pacer_clock,
   input  wire        in_start_trigger,
   input  wire        in_stop_trigger,
   input  wire        in_request_n,
   output reg         in_acknowledge_n_ff,
   // pattern output control lines
   input  wire        out_pacer_clock,
   input  wire        out_start_trigger,
   input  wire        out_stop_trigger,
   input  wire        out_acknowledge_n,
   output reg         out_request_n_ff,
   // transfer side
   input  wire        intPaceTick,
   output reg  [31:0] inPattern_ff,
   output reg         inPatternValid_ff,
   input  wire        inWriteDone,
   input  wire [31:0] outPattern,
   output reg         outPatternTake_ff
);
   // ==========================================================
   // synchronisers
   wire [7:0]  ctlLvl;
   wire [7:0]  ctlRise;
   wire [7:0]  ctlFall;
   wire [31:0] dinLvl;
   wire [31:0] dinRise;
   wire        inReqQual;
   wire        outAckQual;

   // control lines pass two flops before any edge or width logic
   pio_sync_edge #(.W(8)) u_ctl_sync (
      .clock   (clock),
      .rst     (rst),
      .asyncIn ({out_acknowledge_n, in_request_n, out_stop_trigger, in_stop_trigger,
                 out_start_trigger, in_start_trigger, out_pacer_clock, in_pacer_clock}),
      .level   (ctlLvl),
      .rise    (ctlRise),
      .fall    (ctlFall)
   );

   pio_sync_edge #(.W(32)) u_din_sync (
      .clock   (clock),
      .rst     (rst),
      .asyncIn (dataIn),
      .level   (dinLvl),
      .rise    (dinRise),
      .fall    ()
   );

   // request low longer than its minimum before a pattern is taken
   pio_low_qual #(.CW(5), .LIMIT(`PIO_REQ_CYC)) u_req_qual (
      .clock     (clock),
      .rst       (rst),
      .lowLevel  (~ctlLvl[6]),
      .qualified (inReqQual)
   );

   // acknowledge low longer than its threshold marks completion
   pio_low_qual #(.CW(5), .LIMIT(`PIO_ACKQ_CYC)) u_ack_qual (
      .clock     (clock),
      .rst       (rst),
      .lowLevel  (~ctlLvl[7]),
      .qualified (outAckQual)
   );

   // ==========================================================
   // registers
   reg [`PIO_CTRL_W-1:0] ctrl_ff;
   reg [31:0]            gpioOut_ff;
   reg [`PIO_ST_W-1:0]   status_ff;
   reg [`PIO_ST_W-1:0]   mask_ff;
   reg                   inRun_ff;
   reg                   outRun_ff;

   wire [1:0] setting  = ctrl_ff[`PIO_CTRL_SET_HI:`PIO_CTRL_SET_LO];
   wire       gpioMode = ctrl_ff[`PIO_CTRL_GPIO];
   wire       inExt    = ctrl_ff[`PIO_CTRL_INEXT];
   wire       outExt   = ctrl_ff[`PIO_CTRL_OUTEXT];
   wire       inHs     = ctrl_ff[`PIO_CTRL_INHS];
   wire       outHs    = ctrl_ff[`PIO_CTRL_OUTHS];

   // half-word output enables from the setting; unknown code reads as all-in
   function [31:0] oe_of;
      input [1:0] s;
      begin
         case (s)
            `PIO_SET_SPLIT:   oe_of = 32'hFFFF_0000;
            `PIO_SET_ALL_OUT: oe_of = 32'hFFFF_FFFF;
            default:          oe_of = 32'h0000_0000;
         endcase
      end
   endfunction

   // picks the software-chosen edge of a synced trigger
   function edge_sel;
      input risingSel;
      input r;
      input f;
      begin
         edge_sel = risingSel ? r : f;
      end
   endfunction

   wire [31:0] oeMask = oe_of(setting);

   // trigger events, edges chosen by software
   wire inStartEv  = edge_sel(ctrl_ff[`PIO_CTRL_INSTR],  ctlRise[2], ctlFall[2]);
   wire outStartEv = edge_sel(ctrl_ff[`PIO_CTRL_OUTSTR], ctlRise[3], ctlFall[3]);
   wire inStopEv   = edge_sel(ctrl_ff[`PIO_CTRL_INSTPR], ctlRise[4], ctlFall[4]);
   wire outStopEv  = edge_sel(ctrl_ff[`PIO_CTRL_OUTSTPR], ctlRise[5], ctlFall[5]);

   // software commands, one-shot on write
   wire       cmdWr      = regWr & (regAddr == `PIO_REG_CMD);
   wire       swInStart  = cmdWr & regWrData[0];
   wire       swInStop   = cmdWr & regWrData[1];
   wire       swOutStart = cmdWr & regWrData[2];
   wire       swOutStop  = cmdWr & regWrData[3];

   // line interrupts: group a input and general I/O mode only
   wire       lineIrqOn = gpioMode & ~oeMask[0];
   wire [3:0] lineEv    = lineIrqOn ? dinRise[3:0] : 4'h0;

   wire [`PIO_ST_W-1:0] stEvents = {outStopEv, outStartEv, inStopEv, inStartEv, lineEv};

   // ==========================================================
   // register writes, status with set winning over read-clear
   always @(posedge clock) begin
      if (rst) begin
         ctrl_ff    <= `PIO_CTRL_RESET;
         gpioOut_ff <= 32'h0000_0000;
         mask_ff    <= {`PIO_ST_W{1'b0}};
         status_ff  <= {`PIO_ST_W{1'b0}};
      end else begin
         if (regWr && regAddr == `PIO_REG_CTRL)
            ctrl_ff <= regWrData[`PIO_CTRL_W-1:0];
         if (regWr && regAddr == `PIO_REG_DOUT)
            gpioOut_ff <= regWrData;
         if (regWr && regAddr == `PIO_REG_MASK)
            mask_ff <= regWrData[`PIO_ST_W-1:0];
         if (regRd && regAddr == `PIO_REG_STATUS)
            status_ff <= stEvents;
         else
            status_ff <= status_ff | stEvents;
      end
   end

   // one-cycle-late read data; unmapped offsets read zero
   always @(posedge clock) begin
      if (rst) begin
         regRdData_ff <= 32'h0000_0000;
      end else if (regRd) begin
         case (regAddr)
            `PIO_REG_CTRL:   regRdData_ff <= {{(32-`PIO_CTRL_W){1'b0}}, ctrl_ff};
            `PIO_REG_DOUT:   regRdData_ff <= gpioOut_ff;
            `PIO_REG_DIN:    regRdData_ff <= dinLvl & ~oeMask;
            `PIO_REG_STATUS: regRdData_ff <= {{(32-`PIO_ST_W){1'b0}}, status_ff};
            `PIO_REG_MASK:   regRdData_ff <= {{(32-`PIO_ST_W){1'b0}}, mask_ff};
            `PIO_REG_XFER:   regRdData_ff <= {30'h0000_0000, outRun_ff, inRun_ff};
            `PIO_REG_PATIN:  regRdData_ff <= inPattern_ff;
            default:         regRdData_ff <= 32'h0000_0000;
         endcase
      end else begin
         regRdData_ff <= 32'h0000_0000;
      end
   end

   // level interrupt from registered status and mask
   always @(posedge clock) begin
      if (rst)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(status_ff & mask_ff);
   end

   // ==========================================================
   // run flags; stop beats start in the same cycle
   always @(posedge clock) begin
      if (rst) begin
         inRun_ff  <= 1'b0;
         outRun_ff <= 1'b0;
      end else begin
         if (inStopEv || swInStop)
            inRun_ff <= 1'b0;
         else if (inStartEv || swInStart)
            inRun_ff <= 1'b1;
         if (outStopEv || swOutStop)
            outRun_ff <= 1'b0;
         else if (outStartEv || swOutStart)
            outRun_ff <= 1'b1;
      end
   end

   // ==========================================================
   // pattern input: pacer falling edge, internal tick, or handshake
   localparam IN_IDLE = 2'h0;
   localparam IN_WAIT = 2'h1;
   localparam IN_ACK  = 2'h2;

   reg  [1:0] inSt_ff;
   reg  [3:0] ackCnt_ff;
   wire       inPace = inExt ? ctlFall[0] : intPaceTick;
   wire       inTake = inRun_ff & (inHs ? (inSt_ff == IN_IDLE) & inReqQual : inPace);

   always @(posedge clock) begin
      if (rst) begin
         inSt_ff             <= IN_IDLE;
         ackCnt_ff           <= 4'h0;
         inPattern_ff        <= 32'h0000_0000;
         inPatternValid_ff   <= 1'b0;
         in_acknowledge_n_ff <= 1'b1;
      end else begin
         inPatternValid_ff <= inTake;
         if (inTake)
            inPattern_ff <= dinLvl & ~oeMask;
         case (inSt_ff)
            IN_IDLE: begin
               in_acknowledge_n_ff <= 1'b1;
               if (inTake && inHs)
                  inSt_ff <= IN_WAIT;
            end
            IN_WAIT: begin
               // ack only once the memory write is reported done
               if (inWriteDone) begin
                  inSt_ff             <= IN_ACK;
                  ackCnt_ff           <= 4'h0;
                  in_acknowledge_n_ff <= 1'b0;
               end
            end
            IN_ACK: begin
               ackCnt_ff <= ackCnt_ff + 4'h1;
               if (ackCnt_ff == `PIO_ACKO_CYC - 1) begin
                  in_acknowledge_n_ff <= 1'b1;
                  inSt_ff             <= IN_IDLE;
               end
            end
            default: begin
               inSt_ff             <= IN_IDLE;
               in_acknowledge_n_ff <= 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // pattern output: pacer falling edge, internal tick, or handshake
   localparam OUT_IDLE = 2'h0;
   localparam OUT_REQ  = 2'h1;
   localparam OUT_HIGH = 2'h2;

   reg  [1:0] outSt_ff;
   wire       outPace = outExt ? ctlFall[1] : intPaceTick;
   wire       hsDone  = (outSt_ff == OUT_REQ) & outAckQual;
   wire       outAdv  = outRun_ff & (outHs ? hsDone : outPace);

   always @(posedge clock) begin
      if (rst) begin
         outSt_ff          <= OUT_IDLE;
         out_request_n_ff  <= 1'b1;
         outPatternTake_ff <= 1'b0;
         dataOut_ff        <= 32'h0000_0000;
         dataOe_ff         <= 32'h0000_0000;
      end else begin
         dataOe_ff         <= oeMask;
         outPatternTake_ff <= outAdv;
         // idle lines show the software value; a running transfer holds its last pattern
         if (outAdv)
            dataOut_ff <= outPattern;
         else if (!outRun_ff)
            dataOut_ff <= gpioOut_ff;
         case (outSt_ff)
            OUT_IDLE: begin
               out_request_n_ff <= 1'b1;
               if (outRun_ff && outHs) begin
                  outSt_ff         <= OUT_REQ;
                  out_request_n_ff <= 1'b0;
               end
            end
            OUT_REQ: begin
               if (!outRun_ff) begin
                  outSt_ff         <= OUT_IDLE;
                  out_request_n_ff <= 1'b1;
               end else if (hsDone) begin
                  outSt_ff         <= OUT_HIGH;
                  out_request_n_ff <= 1'b1;
               end
            end
            OUT_HIGH: begin
               // wait for ack to rise so one low pulse advances once
               if (ctlLvl[7])
                  outSt_ff <= OUT_IDLE;
            end
            default: begin
               outSt_ff         <= OUT_IDLE;
               out_request_n_ff <= 1'b1;
            end
         endcase
      end
   end
endmodule // pio_front_end

// file: tb/pio_fe_props.sv
// port checker for the pattern I/O front end
`timescale 1ns/1ps
module pio_fe_props (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [31:0] dataOe_ff,
   input wire logic        in_pacer_clock,
   input wire logic        in_request_n,
   input wire logic        in_acknowledge_n_ff,
   input wire logic        out_pacer_clock,
   input wire logic        out_acknowledge_n,
   input wire logic        out_request_n_ff,
   input wire logic        inPatternValid_ff,
   input wire logic        inWriteDone,
   input wire logic        intPaceTick,
   input wire logic        outPatternTake_ff
);
   // ====
   // one domain; reset blanks every check
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_dir_halves: assert property (dataOe_ff == 32'h0000_0000 || dataOe_ff == 32'hFFFF_0000 ||
      dataOe_ff == 32'hFFFF_FFFF) else $error("line enables outside the three settings");
   a_ack_width: assert property ($fell(in_acknowledge_n_ff) |=>
      (!in_acknowledge_n_ff)[*8] ##1 !in_acknowledge_n_ff ##1 in_acknowledge_n_ff) else $error("ack width wrong");
   a_ack_cause: assert property ($fell(in_acknowledge_n_ff) |->
      $past(inWriteDone) || $past(inWriteDone, 2)) else $error("ack without memory write");
   // handshake capture needs a request held low past the minimum
   a_req_qualify: assert property (inPatternValid_ff && !$past(in_request_n, 3) |->
      !$past(in_request_n, 4) && !$past(in_request_n, 9)) else $error("capture on short request");
   // internal ticks pace too; any other untethered take must follow a pacer fall
   a_in_pace: assert property (inPatternValid_ff && $past(in_request_n, 3) && !$past(intPaceTick) |->
      $past(in_pacer_clock, 6) && !$past(in_pacer_clock, 2)) else $error("input not on pacer fall");
   a_out_pace: assert property (outPatternTake_ff && $past(out_request_n_ff) && !$past(intPaceTick) |->
      $past(out_pacer_clock, 6) && !$past(out_pacer_clock, 2)) else $error("output not on pacer fall");
   a_ack_qualify: assert property (outPatternTake_ff && !$past(out_request_n_ff) |->
      !$past(out_acknowledge_n, 4) && !$past(out_acknowledge_n, 12)) else $error("advance on short ack");
   a_req_rearm: assert property ($fell(out_request_n_ff) |->
      $past(out_acknowledge_n, 2)) else $error("request raised while ack low");
   c_ack: cover property ($fell(in_acknowledge_n_ff));
   c_take_hs: cover property (outPatternTake_ff && !$past(out_request_n_ff));
   c_take_pace: cover property (outPatternTake_ff && $past(out_request_n_ff));
endmodule // pio_fe_props
bind pio_front_end pio_fe_props pio_fe_props_inst (.*);

// file: tb/pio_fe_partner.sv
// far-side device model: pacer clocks and both handshakes
`timescale 1ns/1ps
module pio_fe_partner (
   input  wire logic       clock,
   input  wire logic       inClkRun,
   input  wire logic       outClkRun,
   input  wire logic       reqGo,
   input  wire logic [7:0] ackLen,
   input  wire logic       in_acknowledge_n_ff,
   input  wire logic       out_request_n_ff,
   output logic            in_pacer_clock,
   output logic            out_pacer_clock,
   output logic            in_request_n,
   output logic            out_acknowledge_n
);
   logic [7:0] ackCnt_ff;
   // pacers stand high outside frames; own phase, 160 ns period
   initial begin
      in_pacer_clock = 1'b1;
      out_pacer_clock = 1'b1;
      #3;
      forever begin
         #80;
         in_pacer_clock = inClkRun ? ~in_pacer_clock : 1'b1;
         out_pacer_clock = outClkRun ? ~out_pacer_clock : 1'b1;
      end
   end
   // request held until ack falls; next one only once ack is back high
   initial in_request_n = 1'b1;
   always @(posedge clock) begin
      if (!in_request_n && !in_acknowledge_n_ff) in_request_n <= 1'b1;
      else if (reqGo && in_request_n && in_acknowledge_n_ff) in_request_n <= 1'b0;
   end
   // ack low for ackLen cycles, then 8 cycles high before the next try
   initial out_acknowledge_n = 1'b1;
   initial ackCnt_ff = 8'h00;
   always @(posedge clock) begin
      if (ackCnt_ff != 8'h00) ackCnt_ff <= ackCnt_ff - 8'h01;
      else if (!out_request_n_ff) ackCnt_ff <= ackLen + 8'h07;
      out_acknowledge_n <= !(ackCnt_ff > 8'h07);
   end
endmodule // pio_fe_partner

// file: tb/pio_front_end_bench.sv
// self-checking bench for the pattern I/O front end
`timescale 1ns/1ps
`include "pio_consts.vh"
module pio_front_end_bench;
   logic        clock, rst, regWr, regRd, inWriteDone, inClkRun, outClkRun, reqGo, intPaceTick;
   logic [7:0]  regAddr, ackLen;
   logic [3:0]  trig;
   logic [31:0] regWrData, extLines, outPattern;
   wire  [31:0] regRdData_ff, dataOut_ff, dataOe_ff, inPattern_ff, dataIn;
   wire         irq_ff, inPatternValid_ff, outPatternTake_ff, in_acknowledge_n_ff, out_request_n_ff;
   wire         in_pacer_clock, out_pacer_clock, in_request_n, out_acknowledge_n;
   wire         in_start_trigger = trig[0];
   wire         in_stop_trigger = trig[1];
   wire         out_start_trigger = trig[2];
   wire         out_stop_trigger = trig[3];
   int          n_errors, checks_done, nTake, i, k;
   // line level: device drives where enabled, far side elsewhere
   assign dataIn = (dataOe_ff & dataOut_ff) | (~dataOe_ff & extLines);
   pio_front_end pio_front_end_inst (.*);
   pio_fe_partner pio_fe_partner_inst (.*);
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // count pattern advances
   always @(posedge clock) if (outPatternTake_ff === 1'b1) nTake <= nTake + 1;
   // ====
   // tasks
   function automatic logic [31:0] oeOf(input int s);
      return s == 1 ? 32'hFFFF_0000 : s == 2 ? 32'hFFFF_FFFF : 32'h0000_0000;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clock);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk(regRdData_ff, exp);
   endtask
   // bounded wait for a capture (0) or an advance (1)
   task automatic waitv(input logic sel);
      int t;
      t = 0;
      while ((sel ? outPatternTake_ff : inPatternValid_ff) !== 1'b1) begin
         cyc(1);
         t++;
         if (t > 600) begin
            chk({31'h0, sel}, 32'hFFFF_FFFF);
            give_verdict();
         end
      end
   endtask
   // ====
   // main sequence
   initial begin
      rst = 1'b1;
      {regWr, regRd, inWriteDone, inClkRun, outClkRun, reqGo, intPaceTick} = 7'h00;
      regAddr = 8'h00;
      regWrData = 32'h0000_0000;
      trig = 4'h0;
      extLines = 32'h5A5A_A5A5;
      outPattern = 32'h0000_0000;
      ackLen = 8'h0A;
      {nTake, n_errors, checks_done} = 0;
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      cyc(1);
      rdc(`PIO_REG_CTRL, 32'h0000_0004);
      chk({30'h0, in_acknowledge_n_ff, out_request_n_ff}, 32'h0000_0003);
      // low nibble of the output value matches the far side: no line edges
      wr(`PIO_REG_DOUT, 32'hC3C3_3C35);
      for (i = 0; i < 4; i++) begin
         wr(`PIO_REG_CTRL, 32'h0000_0004 | i);
         cyc(3);
         chk(dataOe_ff, oeOf(i));
         chk(dataOut_ff & oeOf(i), 32'hC3C3_3C35 & oeOf(i));
         rdc(`PIO_REG_DIN, 32'h5A5A_A5A5 & ~oeOf(i));
      end
      $display("done: directions");
      extLines <= 32'h0000_0000;
      wr(`PIO_REG_MASK, 32'h0000_0001);
      rdc(`PIO_REG_STATUS, 32'h0000_0000);
      extLines <= 32'h0000_0003;
      cyc(6);
      chk({31'h0, irq_ff}, 32'h0000_0001);
      rdc(`PIO_REG_STATUS, 32'h0000_0003);
      cyc(2);
      chk({31'h0, irq_ff}, 32'h0000_0000);
      extLines <= 32'h0000_0007;
      cyc(6);
      chk({31'h0, irq_ff}, 32'h0000_0000);
      rdc(`PIO_REG_STATUS, 32'h0000_0004);
      wr(`PIO_REG_CTRL, 32'h0000_0000);
      extLines <= 32'h0000_000F;
      cyc(6);
      rdc(`PIO_REG_STATUS, 32'h0000_0000);
      $display("done: line interrupts");
      // each trigger held at least 100 ns per level, both edge choices
      for (i = 0; i < 4; i++) begin
         for (k = 0; k < 2; k++) begin
            wr(`PIO_REG_CTRL, 32'h0000_0004 | (k << (5 + i)));
            trig[i] <= 1'b1;
            cyc(8);
            rdc(`PIO_REG_STATUS, k ? 32'h0000_0010 << i : 32'h0000_0000);
            trig[i] <= 1'b0;
            cyc(8);
            rdc(`PIO_REG_STATUS, k ? 32'h0000_0000 : 32'h0000_0010 << i);
         end
         rdc(`PIO_REG_XFER, i == 0 ? 32'h0000_0001 : i == 2 ? 32'h0000_0002 : 32'h0000_0000);
      end
      $display("done: triggers");
      for (k = 0; k < 2; k++) begin
         wr(`PIO_REG_CTRL, 32'h0000_0200 | k);
         wr(`PIO_REG_CMD, 32'h0000_0001);
         extLines <= 32'h1234_5678 + k;
         cyc(3);
         reqGo <= 1'b1;
         waitv(1'b0);
         reqGo <= 1'b0;
         chk(inPattern_ff, (32'h1234_5678 + k) & ~oeOf(k));
         cyc(5);
         chk({31'h0, in_acknowledge_n_ff}, 32'h0000_0001);
         inWriteDone <= 1'b1;
         cyc(1);
         inWriteDone <= 1'b0;
         cyc(2);
         chk({31'h0, in_acknowledge_n_ff}, 32'h0000_0000);
         cyc(12);
         chk({31'h0, in_acknowledge_n_ff}, 32'h0000_0001);
         wr(`PIO_REG_CMD, 32'h0000_0002);
      end
      $display("done: input handshake");
      // a 100 ns ack must not advance; a 200 ns one must
      outPattern <= 32'hCAFE_0001;
      wr(`PIO_REG_CTRL, 32'h0000_0402);
      wr(`PIO_REG_CMD, 32'h0000_0004);
      cyc(80);
      chk(32'(nTake), 32'h0000_0000);
      ackLen <= 8'h14;
      waitv(1'b1);
      chk(dataOut_ff, 32'hCAFE_0001);
      outPattern <= 32'hCAFE_0002;
      cyc(1);
      waitv(1'b1);
      chk(dataOut_ff, 32'hCAFE_0002);
      wr(`PIO_REG_CMD, 32'h0000_0008);
      $display("done: output handshake");
      wr(`PIO_REG_CTRL, 32'h0000_0019);
      outPattern <= 32'h0BAD_F00D;
      extLines <= 32'h0000_1357;
      wr(`PIO_REG_CMD, 32'h0000_0005);
      inClkRun <= 1'b1;
      outClkRun <= 1'b1;
      waitv(1'b0);
      chk(inPattern_ff, 32'h0000_1357);
      waitv(1'b1);
      chk(dataOut_ff & oeOf(1), 32'h0BAD_0000);
      inClkRun <= 1'b0;
      outClkRun <= 1'b0;
      wr(`PIO_REG_CMD, 32'h0000_000A);
      $display("done: external pacers");
      // internal pacing: one tick moves one word each way
      extLines <= 32'h0000_2468;
      wr(`PIO_REG_CTRL, 32'h0000_0001);
      outPattern <= 32'h1111_2222;
      wr(`PIO_REG_CMD, 32'h0000_0005);
      intPaceTick <= 1'b1;
      cyc(1);
      intPaceTick <= 1'b0;
      chk({inPatternValid_ff, outPatternTake_ff}, 32'h0000_0003);
      chk(inPattern_ff, 32'h0000_2468);
      chk(dataOut_ff & oeOf(1), 32'h1111_0000);
      rdc(`PIO_REG_PATIN, 32'h0000_2468);
      wr(`PIO_REG_CMD, 32'h0000_000A);
      $display("done: internal pacing");
      give_verdict();
   end
endmodule // pio_front_end_bench
